// ### hw/gsso_pkg.sv
// Package: constants and types for the genset supervisory block
package gsso_pkg;

	// ----------------------------------------
	// Customer output source selection
	// ----------------------------------------
	localparam logic [2:0] SEL_NONE       = 3'h0;
	localparam logic [2:0] SEL_WARNING    = 3'h1;
	localparam logic [2:0] SEL_SHUTDOWN   = 3'h2;
	localparam logic [2:0] SEL_RUNNING    = 3'h3;
	localparam logic [2:0] SEL_NOT_READY  = 3'h4;

	// ----------------------------------------
	// Power-down control options
	// ----------------------------------------
	localparam logic [1:0] PD_DISABLE = 2'h1;
	localparam logic [1:0] PD_ENABLE  = 2'h2;
	localparam logic [1:0] PD_FORCE   = 2'h3;
	localparam logic [1:0] PD_RESET   = 2'h2;

	// ----------------------------------------
	// Fault response encoding
	// ----------------------------------------
	localparam logic RESP_WARNING  = 1'h0;
	localparam logic RESP_SHUTDOWN = 1'h1;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint CLK_HZ          = 64'd250000000;
	localparam longint PD_TIME_MIN     = 64'd10;
	localparam longint PD_CYCLES       = PD_TIME_MIN * 64'd60 * CLK_HZ;
	localparam longint TENTH_HOUR_S    = 64'd360;
	localparam longint TENTH_CYCLES    = TENTH_HOUR_S * CLK_HZ;
	localparam int     TENTHS_PER_HOUR = 10;

	// ----------------------------------------
	// PWM
	// ----------------------------------------
	localparam logic [6:0] PCT_FULL   = 7'h64;
	localparam int         PWM_PRESC  = 25;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] HOURS_RESET = 32'h0;

endpackage

// ### hw/gsso_hour_cnt.sv
// Module: engine hour counter with optional load
`timescale 1ns/10ps
module gsso_hour_cnt #(
	parameter int TENTHS = 10
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        load,
	input  wire logic [31:0] load_val,
	output logic      [31:0] hours
);

	// ----------------------------------------
	// Sub-hour accumulator
	// ----------------------------------------
	logic [3:0]  tenth_ff;
	logic [31:0] hours_ff;
	wire         hour_wrap = tick && (tenth_ff == 4'(TENTHS - 1));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tenth_ff <= 4'h0;
			hours_ff <= gsso_pkg::HOURS_RESET;
		end else if (load) begin
			hours_ff <= load_val;
			tenth_ff <= 4'h0;
		end else if (tick) begin
			tenth_ff <= hour_wrap ? 4'h0 : tenth_ff + 4'h1;
			if (hour_wrap) begin
				hours_ff <= hours_ff + 32'h1;
			end
		end
	end

	assign hours = hours_ff;

endmodule

// ### hw/gsso_top.sv
// Module: genset supervisory output, power-down, hour meters and overrides
`timescale 1ns/10ps
// Operation
// - One customer output, driven by exactly one selected source option.
// - Warning option: output on while any warning-response fault is active.
// - Shutdown option: output on while any shutdown-response fault is active.
// - Running option: output on only while engine runs at rated speed.
// - Not-ready option: output on if key off or switch at idle.
// - Self power-down after preset stopped interval, default ten minutes, any key position.
// - Disable option never powers down while it stays selected.
// - Disable option returns to enable once the engine starts.
// - Disable option is never offered for persistent storage.
// - Enable option powers down after full interval on without engine start.
// - Force option powers down immediately, skipping the interval.
// - Two hour counters: one non-resettable, one user-settable.
// - Non-resettable counter starts from zero in a new unit.
// - User may load the settable counter; it keeps counting from there.
// - Display shows hours from the user-settable counter.
// - Each override is a value plus enable; value applies only when enabled.
// - Override enables return inactive at every power-up.
// - Override values live only in volatile storage.
// - Fuel override acts only while stopped; value given in percent.
// - Fuel override drives PWM with duty in percent equal to value.
// - Speed override sets speed setpoint to override value in rpm.
// - Shutdown faults trip the engine; warning faults only indicate.
module gsso_top #(
	parameter int     NFAULT     = 16,
	parameter longint PD_CYC     = gsso_pkg::PD_CYCLES,
	parameter longint TENTH_CYC  = gsso_pkg::TENTH_CYCLES,
	parameter int     PWM_PRESC  = gsso_pkg::PWM_PRESC
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [2:0]        cust_sel,
	input  wire logic [NFAULT-1:0] fault_active,
	input  wire logic [NFAULT-1:0] fault_resp,
	input  wire logic              eng_running,
	input  wire logic              eng_rated,
	input  wire logic              key_on,
	input  wire logic              sw_rated,
	input  wire logic [1:0]        pd_cmd,
	input  wire logic              pd_cmd_wr,
	input  wire logic              hours_load,
	input  wire logic [31:0]       hours_load_val,
	input  wire logic [6:0]        fuel_norm_pct,
	input  wire logic [6:0]        fuel_ovr_val,
	input  wire logic              fuel_ovr_en,
	input  wire logic [15:0]       speed_norm_rpm,
	input  wire logic [15:0]       speed_ovr_val,
	input  wire logic              speed_ovr_en,
	output logic                   cust_out,
	output logic                   power_off,
	output logic [1:0]             pd_mode,
	output logic                   pd_mode_storable,
	output logic                   eng_trip,
	output logic                   warn_lamp,
	output logic [31:0]            hours_fixed,
	output logic [31:0]            hours_display,
	output logic                   fuel_pwm,
	output logic                   fuel_ovr_active,
	output logic [15:0]            speed_setpoint
);

	// ----------------------------------------
	// Fault grouping
	// ----------------------------------------
	// True when an active fault carries the given response level
	function automatic logic any_resp(input logic [NFAULT-1:0] act,
	                                  input logic [NFAULT-1:0] resp,
	                                  input logic              lvl);
		any_resp = |(act & ~(resp ^ {NFAULT{lvl}}));
	endfunction

	wire any_warn = any_resp(fault_active, fault_resp, gsso_pkg::RESP_WARNING);
	wire any_shut = any_resp(fault_active, fault_resp, gsso_pkg::RESP_SHUTDOWN);

	// ----------------------------------------
	// Customer output
	// ----------------------------------------
	logic cust_ff;
	logic nxt_cust;

	always_comb begin
		case (cust_sel)
			gsso_pkg::SEL_WARNING:   nxt_cust = any_warn;
			gsso_pkg::SEL_SHUTDOWN:  nxt_cust = any_shut;
			gsso_pkg::SEL_RUNNING:   nxt_cust = eng_running && eng_rated;
			gsso_pkg::SEL_NOT_READY: nxt_cust = !key_on || !sw_rated;
			// Unused codes hold the output low
			default:                 nxt_cust = 1'b0;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cust_ff <= 1'b0;
		end else begin
			cust_ff <= nxt_cust;
		end
	end

	// ----------------------------------------
	// Trip and warning indication
	// ----------------------------------------
	// Trip and lamp follow the active faults, one cycle late
	logic trip_ff;
	logic warn_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trip_ff <= 1'b0;
			warn_ff <= 1'b0;
		end else begin
			trip_ff <= any_shut;
			warn_ff <= any_warn;
		end
	end

	// ----------------------------------------
	// Power-down control
	// ----------------------------------------
	logic [1:0]  mode_ff;
	logic [1:0]  nxt_mode;
	logic [63:0] pd_cnt_ff;
	logic        off_ff;
	logic        storable_ff;

	// Counter saturates, so a long stop never wraps below the limit
	wire pd_expired = pd_cnt_ff >= 64'(PD_CYC - 64'd1);

	always_comb begin
		nxt_mode = mode_ff;
		if (pd_cmd_wr && pd_cmd != 2'h0) begin
			nxt_mode = pd_cmd;
		end
		// Running beats a same-cycle write of disable
		if (eng_running && nxt_mode == gsso_pkg::PD_DISABLE) begin
			nxt_mode = gsso_pkg::PD_ENABLE;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_ff     <= gsso_pkg::PD_RESET;
			storable_ff <= 1'b1;
		end else begin
			mode_ff     <= nxt_mode;
			storable_ff <= nxt_mode != gsso_pkg::PD_DISABLE;
		end
	end

	// ----------------------------------------
	// Stopped-time counter
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pd_cnt_ff <= 64'h0;
		end else if (eng_running) begin
			pd_cnt_ff <= 64'h0;
		end else if (!pd_expired) begin
			pd_cnt_ff <= pd_cnt_ff + 64'h1;
		end
	end

	// ----------------------------------------
	// Sticky power-down request
	// ----------------------------------------
	// Disable matches neither term, so off_ff stays low
	wire force_hit  = mode_ff == gsso_pkg::PD_FORCE;
	wire expire_hit = mode_ff == gsso_pkg::PD_ENABLE && !eng_running && pd_expired;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			off_ff <= 1'b0;
		end else if (force_hit || expire_hit) begin
			off_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Hour meters
	// ----------------------------------------
	// One time base feeds both meters, so they stay in step
	logic [63:0] tb_cnt_ff;
	logic        tb_tick_ff;
	wire         tb_wrap = tb_cnt_ff == 64'(TENTH_CYC - 64'd1);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tb_cnt_ff  <= 64'h0;
			tb_tick_ff <= 1'b0;
		end else begin
			tb_tick_ff <= eng_running && tb_wrap;
			if (eng_running) begin
				tb_cnt_ff <= tb_wrap ? 64'h0 : tb_cnt_ff + 64'h1;
			end
		end
	end

	logic [31:0] fixed_w;
	logic [31:0] settable_w;

	gsso_hour_cnt #(
		.TENTHS   (gsso_pkg::TENTHS_PER_HOUR)
	) u_fixed (
		.clock    (clock),
		.rst      (rst),
		.tick     (tb_tick_ff),
		.load     (1'b0),
		.load_val (32'h0),
		.hours    (fixed_w)
	);

	gsso_hour_cnt #(
		.TENTHS   (gsso_pkg::TENTHS_PER_HOUR)
	) u_settable (
		.clock    (clock),
		.rst      (rst),
		.tick     (tb_tick_ff),
		.load     (hours_load),
		.load_val (hours_load_val),
		.hours    (settable_w)
	);

	// Output copies add one cycle after each counter step
	logic [31:0] hfix_ff;
	logic [31:0] hdisp_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hfix_ff  <= gsso_pkg::HOURS_RESET;
			hdisp_ff <= gsso_pkg::HOURS_RESET;
		end else begin
			hfix_ff  <= fixed_w;
			hdisp_ff <= settable_w;
		end
	end

	// ----------------------------------------
	// Overrides, volatile only
	// ----------------------------------------
	wire       fuel_use = fuel_ovr_en && !eng_running;
	// Clamp keeps an out-of-range value from exceeding full duty
	wire [6:0] fuel_lim = (fuel_ovr_val > gsso_pkg::PCT_FULL) ? gsso_pkg::PCT_FULL
	                                                          : fuel_ovr_val;
	wire [6:0] duty     = fuel_use ? fuel_lim : fuel_norm_pct;

	// Enables are plain inputs, so no override survives a power-up
	// Speed override is not gated by engine state
	logic [15:0] spd_ff;
	logic        fact_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			spd_ff  <= 16'h0;
			fact_ff <= 1'b0;
		end else begin
			spd_ff  <= speed_ovr_en ? speed_ovr_val : speed_norm_rpm;
			fact_ff <= fuel_use;
		end
	end

	// ----------------------------------------
	// Fuel PWM, 100 steps per period
	// ----------------------------------------
	logic [15:0] pre_ff;
	logic [6:0]  step_ff;
	logic        pwm_ff;
	wire         pre_wrap = pre_ff == 16'(PWM_PRESC - 1);
	// Output lags the step count by one cycle

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pre_ff  <= 16'h0;
			step_ff <= 7'h0;
			pwm_ff  <= 1'b0;
		end else begin
			pre_ff <= pre_wrap ? 16'h0 : pre_ff + 16'h1;
			if (pre_wrap) begin
				step_ff <= (step_ff == gsso_pkg::PCT_FULL - 7'h1) ? 7'h0
				                                                  : step_ff + 7'h1;
			end
			pwm_ff <= step_ff < duty;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign cust_out         = cust_ff;
	assign power_off        = off_ff;
	assign pd_mode          = mode_ff;
	assign pd_mode_storable = storable_ff;
	assign eng_trip         = trip_ff;
	assign warn_lamp        = warn_ff;
	assign hours_fixed      = hfix_ff;
	assign hours_display    = hdisp_ff;
	assign fuel_pwm         = pwm_ff;
	assign fuel_ovr_active  = fact_ff;
	assign speed_setpoint   = spd_ff;

endmodule

// ### verif/gsso_assertions.sv
// Checker: port-level properties of the supervisory block
`timescale 1ns/10ps
module gsso_assertions #(
	parameter int NFAULT = 16
) (
	input wire logic              clock,
	input wire logic              rst,
	input wire logic [2:0]        cust_sel,
	input wire logic [NFAULT-1:0] fault_active,
	input wire logic [NFAULT-1:0] fault_resp,
	input wire logic              eng_running,
	input wire logic              eng_rated,
	input wire logic              key_on,
	input wire logic              sw_rated,
	input wire logic [1:0]        pd_cmd,
	input wire logic              pd_cmd_wr,
	input wire logic              fuel_ovr_en,
	input wire logic [15:0]       speed_norm_rpm,
	input wire logic [15:0]       speed_ovr_val,
	input wire logic              speed_ovr_en,
	input wire logic              cust_out,
	input wire logic              power_off,
	input wire logic [1:0]        pd_mode,
	input wire logic              pd_mode_storable,
	input wire logic              eng_trip,
	input wire logic [31:0]       hours_fixed,
	input wire logic              fuel_pwm,
	input wire logic              fuel_ovr_active,
	input wire logic [15:0]       speed_setpoint
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_warn_out: assert property (cust_sel == 3'h1 |=>
		cust_out == $past(|(fault_active & ~fault_resp))) else $error("bad warning output");
	a_shut_out: assert property (cust_sel == 3'h2 |=>
		cust_out == $past(|(fault_active & fault_resp))) else $error("bad shutdown output");
	a_run_out: assert property (cust_sel == 3'h3 |=>
		cust_out == $past(eng_running && eng_rated)) else $error("bad running output");
	a_ready_out: assert property (cust_sel == 3'h4 |=>
		cust_out == $past(!key_on || !sw_rated)) else $error("bad not-ready output");
	a_sel_other: assert property (!(cust_sel inside {[3'h1:3'h4]}) |=>
		!cust_out) else $error("output on with no source");
	a_force_off: assert property (pd_cmd_wr && pd_cmd == 2'h3 |-> ##2 power_off)
		else $error("force did not power down");
	a_disable_hold: assert property (pd_mode == 2'h1 && !power_off |=> !power_off)
		else $error("powered down while disabled");
	a_revert_run: assert property (eng_running |=> pd_mode != 2'h1)
		else $error("disable kept while running");
	a_mode_store: assert property (pd_mode_storable == (pd_mode != 2'h1))
		else $error("disable marked storable");
	a_fuel_gate: assert property (1 |=>
		fuel_ovr_active == $past(fuel_ovr_en && !eng_running)) else $error("bad fuel gate");
	a_speed_sel: assert property (1 |=> speed_setpoint ==
		$past(speed_ovr_en ? speed_ovr_val : speed_norm_rpm)) else $error("bad setpoint");
	a_trip_any: assert property (1 |=>
		eng_trip == $past(|(fault_active & fault_resp))) else $error("bad trip");
	a_hours_hold: assert property (!eng_running [*4] |=> $stable(hours_fixed))
		else $error("hours moved while stopped");

	cover property (pd_cmd_wr && pd_cmd == 2'h3 ##2 power_off);
	cover property (cust_sel == 3'h4 ##1 cust_out);
	cover property (fuel_ovr_active && fuel_pwm);
endmodule

bind gsso_top gsso_assertions #(.NFAULT(NFAULT)) i_chk (.*);

// ### verif/gsso_engine_model.sv
// Partner: engine switch response and fuel actuator duty meter
`timescale 1ns/10ps
module gsso_engine_model #(
	parameter int PRESC = 2
) (
	input  wire logic clock,
	input  wire logic crank,
	input  wire logic fuel_pwm,
	output logic      eng_running,
	output logic      eng_rated,
	output int        hi_cnt
);
	int win = 0;
	int acc = 0;

	initial begin
		eng_running = 1'b0;
		eng_rated = 1'b0;
		hi_cnt = 0;
	end
	// Rated speed one cycle after running
	always @(posedge clock) begin
		eng_running <= crank;
		eng_rated <= eng_running & crank;
	end
	// High cycles in each full PWM period
	always @(posedge clock) begin
		if (win == 100 * PRESC - 1) begin
			win <= 0;
			acc <= 0;
			hi_cnt <= acc + int'(fuel_pwm);
		end else begin
			win <= win + 1;
			acc <= acc + int'(fuel_pwm);
		end
	end
endmodule

// ### verif/gsso_top_test.sv
// Testbench: self-checking run of the supervisory block
`timescale 1ns/10ps
module gsso_top_test;
	localparam int PRESC = 2;
	logic        clock = 1'b0, rst = 1'b1, crank = 1'b0, key_on = 1'b0, sw_rated = 1'b0;
	logic        pd_cmd_wr = 1'b0, hours_load = 1'b0, fuel_ovr_en = 1'b0, speed_ovr_en = 1'b0;
	logic [2:0]  cust_sel = 3'h0;
	logic [1:0]  pd_cmd = 2'h0;
	logic [15:0] fault_active = 16'h0, fault_resp = 16'h0;
	logic [15:0] speed_norm_rpm = 16'h0, speed_ovr_val = 16'h0;
	logic [31:0] hours_load_val = 32'h0;
	logic [6:0]  fuel_norm_pct = 7'h0, fuel_ovr_val = 7'h0;
	logic        eng_running, eng_rated, cust_out, power_off, pd_mode_storable, eng_trip;
	logic        warn_lamp, fuel_pwm, fuel_ovr_active;
	logic [1:0]  pd_mode;
	logic [31:0] hours_fixed, hours_display;
	logic [15:0] speed_setpoint;
	int          hi_cnt, errors = 0, cmp_count = 0;
	logic [31:0] exp_q[$];
	int          id_q[$];

	gsso_top #(.PD_CYC(50), .TENTH_CYC(20), .PWM_PRESC(PRESC)) i_dut (.*);
	gsso_engine_model #(.PRESC(PRESC)) i_eng (.clock(clock), .crank(crank),
		.fuel_pwm(fuel_pwm), .eng_running(eng_running), .eng_rated(eng_rated), .hi_cnt(hi_cnt));

	initial forever #2 clock = ~clock;

	function logic [31:0] obs(input int id);
		case (id)
			0: obs = 32'(cust_out);
			1: obs = 32'(power_off);
			2: obs = 32'(pd_mode);
			3: obs = hours_display;
			4: obs = hours_fixed;
			5: obs = 32'(speed_setpoint);
			6: obs = 32'(hi_cnt);
			7: obs = 32'(pd_mode_storable);
			8: obs = 32'(eng_trip);
			9: obs = 32'(warn_lamp);
			default: obs = 32'(fuel_ovr_active);
		endcase
	endfunction
	function logic exp_cust();
		case (cust_sel)
			3'h1: exp_cust = |(fault_active & ~fault_resp);
			3'h2: exp_cust = |(fault_active & fault_resp);
			3'h3: exp_cust = eng_running & eng_rated;
			3'h4: exp_cust = !key_on | !sw_rated;
			default: exp_cust = 1'b0;
		endcase
	endfunction
	task note(input int id, input logic [31:0] v);
		id_q.push_back(id);
		exp_q.push_back(v);
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task do_reset();
		cyc(1);
		rst = 1'b1;
		cyc(4);
		rst = 1'b0;
	endtask
	task wr_pd(input logic [1:0] c);
		pd_cmd = c;
		pd_cmd_wr = 1'b1;
		cyc(1);
		pd_cmd_wr = 1'b0;
	endtask
	task summarize();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----
	// Monitor: every pending note against settled outputs
	// ----
	always @(posedge clock) begin
		while (id_q.size() > 0) begin
			cmp_count++;
			if (obs(id_q[0]) !== exp_q[0]) begin
				errors++;
				$display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp_q[0], obs(id_q[0]));
			end
			void'(id_q.pop_front());
			void'(exp_q.pop_front());
		end
	end

	initial begin
		#40000;
		errors++;
		summarize();
	end

	initial begin
		logic [31:0] v;
		void'($urandom(32'h38D2DA61));
		cyc(4);
		rst = 1'b0;
		note(2, 32'h2);
		note(0, 32'h0);
		note(4, 32'h0);
		note(10, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 32; i++) begin
			crank = 1'($urandom);
			cyc(2);
			cust_sel = 3'(i % 8);
			fault_active = 16'($urandom & $urandom);
			fault_resp = 16'($urandom);
			key_on = 1'($urandom);
			sw_rated = 1'($urandom);
			speed_ovr_en = 1'($urandom);
			speed_ovr_val = 16'($urandom);
			speed_norm_rpm = 16'($urandom);
			cyc(1);
			note(0, 32'(exp_cust()));
			note(8, 32'(|(fault_active & fault_resp)));
			note(9, 32'(|(fault_active & ~fault_resp)));
			note(5, 32'(speed_ovr_en ? speed_ovr_val : speed_norm_rpm));
		end
		$display("test customer output done");
		do_reset();
		crank = 1'b1;
		cyc(450);
		crank = 1'b0;
		cyc(310);
		note(4, 32'h2);
		note(3, 32'h2);
		v = $urandom & 32'h00FF_FFFF;
		hours_load_val = v;
		hours_load = 1'b1;
		cyc(1);
		hours_load = 1'b0;
		cyc(2);
		note(3, v);
		crank = 1'b1;
		cyc(250);
		crank = 1'b0;
		cyc(10);
		note(3, v + 32'h1);
		note(4, 32'h3);
		$display("test hour meters done");
		do_reset();
		wr_pd(2'h2);
		cyc(48);
		note(1, 32'h0);
		cyc(1);
		note(1, 32'h1);
		do_reset();
		wr_pd(2'h1);
		cyc(200);
		note(1, 32'h0);
		note(7, 32'h0);
		crank = 1'b1;
		cyc(3);
		note(2, 32'h2);
		crank = 1'b0;
		cyc(3);
		wr_pd(2'h3);
		cyc(2);
		note(1, 32'h1);
		$display("test power-down done");
		do_reset();
		fuel_norm_pct = 7'($urandom_range(100));
		for (int k = 0; k < 2; k++) begin
			fuel_ovr_val = (k == 1) ? 7'h64 : 7'($urandom_range(99));
			fuel_ovr_en = 1'b1;
			cyc(450);
			note(6, 32'(fuel_ovr_val) * PRESC);
			note(10, 32'h1);
			crank = 1'b1;
			cyc(450);
			note(6, 32'(fuel_norm_pct) * PRESC);
			note(10, 32'h0);
			crank = 1'b0;
		end
		$display("test overrides done");
		cyc(2);
		summarize();
	end
endmodule
